/* src/l2ctl_pkg.sv */
package l2ctl_pkg;

   // ==========================================================
   // widths and positions
   localparam int TAG_W = 8;
   localparam int LANES = 8;
   localparam int SDRAM_CONTROL_REG_FIFTH_BIT = 1;
   localparam int CEC_DRAM_CACHE_BIT = 5;
   localparam int LINE_QWORDS = 4;

   // ==========================================================
   // values after reset
   localparam logic [7:0] SDRAM_CONTROL_REG_RST = 8'h00;
   localparam logic [7:0] CEC_RST = 8'h00;
   localparam logic [7:0] TAG_RST = 8'h00;

   // ==========================================================
   // cycle counts
   localparam int STEP_BITS = 2;
   localparam logic [1:0] LAST_STEP = 2'h3;
   localparam logic [1:0] STRAP_WAIT = 2'h2;

   typedef enum logic [2:0] {
      L2CTL_IDLE,
      L2CTL_READ,
      L2CTL_WRITE,
      L2CTL_FILL,
      L2CTL_TAGWR,
      L2CTL_SLEEP
   } l2ctl_state_e;

   typedef enum logic [1:0] {
      L2CTL_OP_READ  = 2'h0,
      L2CTL_OP_WRITE = 2'h1,
      L2CTL_OP_FILL  = 2'h2,
      L2CTL_OP_INVAL = 2'h3
   } l2ctl_op_e;

endpackage : l2ctl_pkg

/* src/l2ctl_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two flop synchroniser, first stage read only by the second
module l2ctl_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta_reg <= '0;
         q_out <= '0;
      end else begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end
endmodule : l2ctl_sync
`default_nettype wire

/* src/l2ctl_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - pulse burst-step low to advance data SRAM to next qword of line
// - address-load with select active wakes SRAM and performs an access
// - address-load with select inactive sends SRAM into power-down
// - read drive low only during cache-to-processor transfers
// - all-lanes write writes every byte lane regardless of byte enables
// - partial write: all-lanes high, lane write low, byte enables pick lanes
// - tag bus input on processor accesses, output on fills and invalidates
// - tag store strobe writes presented tag and state into tag RAM
// - DRAM-cache configuration uses shared pin as refresh handshake
// - shared pin sampled at hard reset to detect DRAM cache, default none
// - alternate function: shared pin is fifth SDRAM row select
// - fifth select only if sdram bit1 is 1 and cache config bit5 is 0
module l2ctl_top (
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic REQ_VALID_IN,
   input wire logic [1:0] REQ_OP_IN,
   input wire logic REQ_PARTIAL_IN,
   input wire logic [7:0] REQ_TAG_IN,
   input wire logic SLEEP_REQ_IN,
   input wire logic [7:0] SDRAM_CONTROL_REG_IN,
   input wire logic [7:0] CACHE_CONFIG_REG_IN,
   input wire logic FIFTH_ROW_SELECT_REQ_IN,
   input wire logic REFRESH_REQ_IN,
   input wire logic [7:0] TAG_BUS_IN,
   input wire logic DRAM_CACHE_REFRESH_HANDSHAKE_IN,
   output logic REQ_READY_OUT,
   output logic DONE_OUT,
   output logic [7:0] TAG_READ_OUT,
   output logic REFRESH_ACK_OUT,
   output logic REFRESH_REQ_SEEN_OUT,
   output logic DRAM_CACHE_PRESENT_OUT,
   output logic L2_BURST_STEP_N_OUT,
   output logic L2_ADDR_LOAD_N_OUT,
   output logic L2_SELECT_N_OUT,
   output logic L2_READ_DRIVE_N_OUT,
   output logic L2_ALL_LANES_WRITE_N_OUT,
   output logic L2_LANE_WRITE_N_OUT,
   output logic [7:0] TAG_BUS_OUT,
   output logic TAG_BUS_OE_OUT,
   output logic TAG_STORE_N_OUT,
   output logic DRAM_CACHE_REFRESH_HANDSHAKE_OUT,
   output logic DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT,
   output logic FIFTH_ROW_SELECT_N_OUT
);
   // ==========================================================
   // input synchronisers
   logic [7:0] tag_sync;
   logic shared_sync;
   logic strap_taken_reg;
   logic dram_cache_reg;
   logic fifth_mode;
   logic fifth_mode_reg;
   logic [1:0] strap_wait_reg;
   logic [1:0] step_reg;
   logic partial_reg;
   logic [7:0] tag_reg;
   logic sleeping_reg;
   logic hs_out_reg;
   l2ctl_pkg::l2ctl_state_e state_reg;
   l2ctl_pkg::l2ctl_op_e op_reg;

   l2ctl_sync #(.W(8)) u_tag_sync (
      .clk_in(CLK_IN),
      .nrst_in(NRST_IN),
      .d_in(TAG_BUS_IN),
      .q_out(tag_sync)
   );

   l2ctl_sync #(.W(1)) u_shared_sync (
      .clk_in(CLK_IN),
      .nrst_in(NRST_IN),
      .d_in(DRAM_CACHE_REFRESH_HANDSHAKE_IN),
      .q_out(shared_sync)
   );

   // ==========================================================
   // strap capture: the synchroniser shows its reset value for two edges,
   // so the capture waits until the pin level has crossed it;
   // the pin's pull-down makes the default no DRAM cache
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         strap_wait_reg <= '0;
         strap_taken_reg <= 1'b0;
         dram_cache_reg <= 1'b0;
      end else if (!strap_taken_reg) begin
         if (strap_wait_reg == l2ctl_pkg::STRAP_WAIT) begin
            strap_taken_reg <= 1'b1;
            dram_cache_reg <= shared_sync;
         end else begin
            strap_wait_reg <= strap_wait_reg + 2'h1;
         end
      end
   end

   assign DRAM_CACHE_PRESENT_OUT = dram_cache_reg;

   assign fifth_mode = SDRAM_CONTROL_REG_IN[l2ctl_pkg::SDRAM_CONTROL_REG_FIFTH_BIT]
      && !CACHE_CONFIG_REG_IN[l2ctl_pkg::CEC_DRAM_CACHE_BIT];

   // ==========================================================
   // shared pin: fifth row select or refresh handshake
   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         fifth_mode_reg <= 1'b0;
         FIFTH_ROW_SELECT_N_OUT <= 1'b1;
         hs_out_reg <= 1'b0;
         REFRESH_REQ_SEEN_OUT <= 1'b0;
      end else begin
         fifth_mode_reg <= fifth_mode;
         FIFTH_ROW_SELECT_N_OUT <= !(fifth_mode && FIFTH_ROW_SELECT_REQ_IN);
         hs_out_reg <= !fifth_mode && REFRESH_REQ_IN;
         REFRESH_REQ_SEEN_OUT <= !fifth_mode && !REFRESH_REQ_IN && shared_sync;
      end
   end

   // fifth select drives the pin low-active, so its enable is always on;
   // the mode is registered so function, value and enable switch together
   assign DRAM_CACHE_REFRESH_HANDSHAKE_OUT = fifth_mode_reg ? FIFTH_ROW_SELECT_N_OUT : hs_out_reg;
   assign DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT = fifth_mode_reg || hs_out_reg;
   assign REFRESH_ACK_OUT = REFRESH_REQ_SEEN_OUT;

   // ==========================================================
   // cache access sequencer
   assign REQ_READY_OUT = (state_reg == l2ctl_pkg::L2CTL_IDLE)
      || (state_reg == l2ctl_pkg::L2CTL_SLEEP);

   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         state_reg <= l2ctl_pkg::L2CTL_IDLE;
         op_reg <= l2ctl_pkg::L2CTL_OP_READ;
         step_reg <= '0;
         partial_reg <= 1'b0;
         tag_reg <= l2ctl_pkg::TAG_RST;
         sleeping_reg <= 1'b0;
      end else begin
         case (state_reg)
            l2ctl_pkg::L2CTL_IDLE, l2ctl_pkg::L2CTL_SLEEP: begin
               step_reg <= '0;
               if (REQ_VALID_IN) begin
                  op_reg <= l2ctl_pkg::l2ctl_op_e'(REQ_OP_IN);
                  partial_reg <= REQ_PARTIAL_IN;
                  tag_reg <= REQ_TAG_IN;
                  sleeping_reg <= 1'b0;
                  case (l2ctl_pkg::l2ctl_op_e'(REQ_OP_IN))
                     l2ctl_pkg::L2CTL_OP_READ: state_reg <= l2ctl_pkg::L2CTL_READ;
                     l2ctl_pkg::L2CTL_OP_WRITE: state_reg <= l2ctl_pkg::L2CTL_WRITE;
                     l2ctl_pkg::L2CTL_OP_FILL: state_reg <= l2ctl_pkg::L2CTL_FILL;
                     default: state_reg <= l2ctl_pkg::L2CTL_TAGWR;
                  endcase
               end else if (SLEEP_REQ_IN && !sleeping_reg) begin
                  sleeping_reg <= 1'b1;
                  state_reg <= l2ctl_pkg::L2CTL_SLEEP;
               end
            end
            l2ctl_pkg::L2CTL_READ, l2ctl_pkg::L2CTL_WRITE, l2ctl_pkg::L2CTL_FILL: begin
               step_reg <= step_reg + 2'h1;
               if (step_reg == l2ctl_pkg::LAST_STEP) begin
                  state_reg <= (state_reg == l2ctl_pkg::L2CTL_READ)
                     ? l2ctl_pkg::L2CTL_IDLE : l2ctl_pkg::L2CTL_TAGWR;
               end
            end
            l2ctl_pkg::L2CTL_TAGWR: state_reg <= l2ctl_pkg::L2CTL_IDLE;
            default: state_reg <= l2ctl_pkg::L2CTL_IDLE;
         endcase
      end
   end

   // ==========================================================
   // sram and tag strobes, all registered
   logic start_access;
   logic in_burst;
   logic is_write;
   // invalidates touch only the tag ram; a load here would wake or sleep the data sram
   assign start_access = REQ_READY_OUT && REQ_VALID_IN
      && (l2ctl_pkg::l2ctl_op_e'(REQ_OP_IN) != l2ctl_pkg::L2CTL_OP_INVAL);
   assign in_burst = (state_reg == l2ctl_pkg::L2CTL_READ)
      || (state_reg == l2ctl_pkg::L2CTL_WRITE) || (state_reg == l2ctl_pkg::L2CTL_FILL);
   assign is_write = (state_reg == l2ctl_pkg::L2CTL_WRITE)
      || (state_reg == l2ctl_pkg::L2CTL_FILL);

   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         L2_ADDR_LOAD_N_OUT <= 1'b1;
         L2_SELECT_N_OUT <= 1'b1;
         L2_BURST_STEP_N_OUT <= 1'b1;
         L2_READ_DRIVE_N_OUT <= 1'b1;
         L2_ALL_LANES_WRITE_N_OUT <= 1'b1;
         L2_LANE_WRITE_N_OUT <= 1'b1;
         TAG_STORE_N_OUT <= 1'b1;
         TAG_BUS_OE_OUT <= 1'b0;
         TAG_BUS_OUT <= l2ctl_pkg::TAG_RST;
         TAG_READ_OUT <= l2ctl_pkg::TAG_RST;
         DONE_OUT <= 1'b0;
      end else begin
         // load with select low performs the access, load with select high
         // puts the sram to sleep; select high also masks processor strobes
         L2_ADDR_LOAD_N_OUT <= !(start_access
            || (state_reg == l2ctl_pkg::L2CTL_IDLE && SLEEP_REQ_IN && !sleeping_reg
                && !REQ_VALID_IN));
         L2_SELECT_N_OUT <= !(start_access || (in_burst
            && step_reg != l2ctl_pkg::LAST_STEP));
         L2_BURST_STEP_N_OUT <= !(in_burst && step_reg != l2ctl_pkg::LAST_STEP);
         // reads only; writes never overlap the read drive
         L2_READ_DRIVE_N_OUT <= !(state_reg == l2ctl_pkg::L2CTL_READ);
         L2_ALL_LANES_WRITE_N_OUT <= !(is_write
            && !(state_reg == l2ctl_pkg::L2CTL_WRITE && partial_reg));
         L2_LANE_WRITE_N_OUT <= !(state_reg == l2ctl_pkg::L2CTL_WRITE && partial_reg);
         TAG_STORE_N_OUT <= !(state_reg == l2ctl_pkg::L2CTL_TAGWR);
         // tag bus drives only for fills and invalidates
         TAG_BUS_OE_OUT <= (state_reg == l2ctl_pkg::L2CTL_FILL)
            || (state_reg == l2ctl_pkg::L2CTL_TAGWR
                && (op_reg == l2ctl_pkg::L2CTL_OP_FILL
                    || op_reg == l2ctl_pkg::L2CTL_OP_INVAL));
         TAG_BUS_OUT <= tag_reg;
         if (state_reg == l2ctl_pkg::L2CTL_READ || state_reg == l2ctl_pkg::L2CTL_WRITE) begin
            TAG_READ_OUT <= tag_sync;
         end
         DONE_OUT <= (state_reg == l2ctl_pkg::L2CTL_TAGWR)
            || (state_reg == l2ctl_pkg::L2CTL_READ && step_reg == l2ctl_pkg::LAST_STEP);
      end
   end
endmodule : l2ctl_top
`default_nettype wire

/* tb/l2ctl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// strobe checks on the cache control pins
module l2ctl_assertions (
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic [7:0] SDRAM_CONTROL_REG_IN,
   input wire logic [7:0] CACHE_CONFIG_REG_IN,
   input wire logic L2_BURST_STEP_N_OUT,
   input wire logic L2_ADDR_LOAD_N_OUT,
   input wire logic L2_SELECT_N_OUT,
   input wire logic L2_READ_DRIVE_N_OUT,
   input wire logic L2_ALL_LANES_WRITE_N_OUT,
   input wire logic L2_LANE_WRITE_N_OUT,
   input wire logic TAG_BUS_OE_OUT,
   input wire logic TAG_STORE_N_OUT,
   input wire logic DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT
);
   logic fifth;
   assign fifth = SDRAM_CONTROL_REG_IN[1] & ~CACHE_CONFIG_REG_IN[5];
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!NRST_IN);
   AST_STEP: assert property ($fell(L2_BURST_STEP_N_OUT) |->
      !L2_BURST_STEP_N_OUT [*3] ##1 L2_BURST_STEP_N_OUT) else $error("burst step width");
   AST_LOAD: assert property (!L2_ADDR_LOAD_N_OUT && !L2_SELECT_N_OUT |->
      ##1 !L2_BURST_STEP_N_OUT) else $error("no burst after load");
   AST_SLEEP: assert property (!L2_ADDR_LOAD_N_OUT && L2_SELECT_N_OUT |=>
      L2_ADDR_LOAD_N_OUT && L2_BURST_STEP_N_OUT) else $error("sleep not single");
   AST_DRIVE: assert property ($fell(L2_READ_DRIVE_N_OUT) |->
      !L2_READ_DRIVE_N_OUT [*4] ##1 L2_READ_DRIVE_N_OUT) else $error("read drive width");
   AST_PART: assert property (!L2_LANE_WRITE_N_OUT |-> L2_ALL_LANES_WRITE_N_OUT)
      else $error("lane write with all lanes");
   AST_CLASH: assert property (!L2_READ_DRIVE_N_OUT |->
      L2_ALL_LANES_WRITE_N_OUT && L2_LANE_WRITE_N_OUT) else $error("read drive with write");
   AST_TAGDIR: assert property (TAG_BUS_OE_OUT |-> L2_READ_DRIVE_N_OUT)
      else $error("tag bus driven in cpu read");
   AST_TAGSTORE: assert property ($fell(TAG_STORE_N_OUT) |=> TAG_STORE_N_OUT)
      else $error("tag store too long");
   AST_FIFTH: assert property (fifth && $past(fifth) && $past(NRST_IN) |->
      DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT) else $error("fifth select not driven");
   cover property ($fell(L2_READ_DRIVE_N_OUT));
   cover property (!L2_LANE_WRITE_N_OUT);
   cover property (!L2_ADDR_LOAD_N_OUT && L2_SELECT_N_OUT);
   cover property (fifth && DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT);
endmodule : l2ctl_assertions
bind l2ctl_top l2ctl_assertions i_l2ctl_assertions (
   .CLK_IN(CLK_IN),
   .NRST_IN(NRST_IN),
   .SDRAM_CONTROL_REG_IN(SDRAM_CONTROL_REG_IN),
   .CACHE_CONFIG_REG_IN(CACHE_CONFIG_REG_IN),
   .L2_BURST_STEP_N_OUT(L2_BURST_STEP_N_OUT),
   .L2_ADDR_LOAD_N_OUT(L2_ADDR_LOAD_N_OUT),
   .L2_SELECT_N_OUT(L2_SELECT_N_OUT),
   .L2_READ_DRIVE_N_OUT(L2_READ_DRIVE_N_OUT),
   .L2_ALL_LANES_WRITE_N_OUT(L2_ALL_LANES_WRITE_N_OUT),
   .L2_LANE_WRITE_N_OUT(L2_LANE_WRITE_N_OUT),
   .TAG_BUS_OE_OUT(TAG_BUS_OE_OUT),
   .TAG_STORE_N_OUT(TAG_STORE_N_OUT),
   .DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT(DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT)
);
`default_nettype wire

/* tb/l2ctl_sram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// data sram power state and external tag ram
module l2ctl_sram_model (
   input wire logic clk_in,
   input wire logic addr_load_n_in,
   input wire logic select_n_in,
   input wire logic tag_store_n_in,
   input wire logic tag_oe_in,
   input wire logic [7:0] tag_out_in,
   output logic [7:0] tag_in_out,
   output logic asleep_out
);
   logic [7:0] tag_mem = 8'h00;
   initial asleep_out = 1'b0;
   always @(posedge clk_in) begin
      if (!addr_load_n_in) asleep_out <= select_n_in;
      if (!tag_store_n_in) tag_mem <= tag_in_out;
   end
   // the tag ram drives its outputs whenever the controller lets go of the bus
   assign tag_in_out = tag_oe_in ? tag_out_in : tag_mem;
endmodule : l2ctl_sram_model
`default_nettype wire

/* tb/l2ctl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module l2ctl_tb_top;
   logic CLK_IN, NRST_IN, REQ_VALID_IN, REQ_PARTIAL_IN, SLEEP_REQ_IN, REFRESH_REQ_IN;
   logic FIFTH_ROW_SELECT_REQ_IN, DRAM_CACHE_REFRESH_HANDSHAKE_IN, REQ_READY_OUT, DONE_OUT;
   logic REFRESH_ACK_OUT, REFRESH_REQ_SEEN_OUT, DRAM_CACHE_PRESENT_OUT, L2_BURST_STEP_N_OUT;
   logic L2_ADDR_LOAD_N_OUT, L2_SELECT_N_OUT, L2_READ_DRIVE_N_OUT, L2_ALL_LANES_WRITE_N_OUT;
   logic L2_LANE_WRITE_N_OUT, TAG_BUS_OE_OUT, TAG_STORE_N_OUT, FIFTH_ROW_SELECT_N_OUT;
   logic DRAM_CACHE_REFRESH_HANDSHAKE_OUT, DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT, krq, asleep;
   logic [1:0] REQ_OP_IN;
   logic [7:0] REQ_TAG_IN, SDRAM_CONTROL_REG_IN, CACHE_CONFIG_REG_IN, TAG_BUS_IN;
   logic [7:0] TAG_READ_OUT, TAG_BUS_OUT, tag_q;
   int mismatches = 0;
   int samples_checked = 0;
   int lat[4] = '{5, 6, 6, 2};
   // a released shared pin takes the level that krq drives, as strap or DRAM-cache refresh request
   assign DRAM_CACHE_REFRESH_HANDSHAKE_IN =
      DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT ? DRAM_CACHE_REFRESH_HANDSHAKE_OUT : krq;
   l2ctl_top i_l2ctl_top (
      .CLK_IN(CLK_IN),
      .NRST_IN(NRST_IN),
      .REQ_VALID_IN(REQ_VALID_IN),
      .REQ_OP_IN(REQ_OP_IN),
      .REQ_PARTIAL_IN(REQ_PARTIAL_IN),
      .REQ_TAG_IN(REQ_TAG_IN),
      .SLEEP_REQ_IN(SLEEP_REQ_IN),
      .SDRAM_CONTROL_REG_IN(SDRAM_CONTROL_REG_IN),
      .CACHE_CONFIG_REG_IN(CACHE_CONFIG_REG_IN),
      .FIFTH_ROW_SELECT_REQ_IN(FIFTH_ROW_SELECT_REQ_IN),
      .REFRESH_REQ_IN(REFRESH_REQ_IN),
      .TAG_BUS_IN(TAG_BUS_IN),
      .DRAM_CACHE_REFRESH_HANDSHAKE_IN(DRAM_CACHE_REFRESH_HANDSHAKE_IN),
      .REQ_READY_OUT(REQ_READY_OUT),
      .DONE_OUT(DONE_OUT),
      .TAG_READ_OUT(TAG_READ_OUT),
      .REFRESH_ACK_OUT(REFRESH_ACK_OUT),
      .REFRESH_REQ_SEEN_OUT(REFRESH_REQ_SEEN_OUT),
      .DRAM_CACHE_PRESENT_OUT(DRAM_CACHE_PRESENT_OUT),
      .L2_BURST_STEP_N_OUT(L2_BURST_STEP_N_OUT),
      .L2_ADDR_LOAD_N_OUT(L2_ADDR_LOAD_N_OUT),
      .L2_SELECT_N_OUT(L2_SELECT_N_OUT),
      .L2_READ_DRIVE_N_OUT(L2_READ_DRIVE_N_OUT),
      .L2_ALL_LANES_WRITE_N_OUT(L2_ALL_LANES_WRITE_N_OUT),
      .L2_LANE_WRITE_N_OUT(L2_LANE_WRITE_N_OUT),
      .TAG_BUS_OUT(TAG_BUS_OUT),
      .TAG_BUS_OE_OUT(TAG_BUS_OE_OUT),
      .TAG_STORE_N_OUT(TAG_STORE_N_OUT),
      .DRAM_CACHE_REFRESH_HANDSHAKE_OUT(DRAM_CACHE_REFRESH_HANDSHAKE_OUT),
      .DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT(DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT),
      .FIFTH_ROW_SELECT_N_OUT(FIFTH_ROW_SELECT_N_OUT)
   );
   l2ctl_sram_model i_l2ctl_sram_model (.clk_in(CLK_IN), .addr_load_n_in(L2_ADDR_LOAD_N_OUT),
      .select_n_in(L2_SELECT_N_OUT), .tag_store_n_in(TAG_STORE_N_OUT),
      .tag_oe_in(TAG_BUS_OE_OUT), .tag_out_in(TAG_BUS_OUT), .tag_in_out(TAG_BUS_IN),
      .asleep_out(asleep));
   // ==========================================================
   // tasks
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic run_op(input logic [1:0] op, input logic part, input logic [7:0] tg);
      int n = 0, st = 0, rd = 0, al = 0, ln = 0;
      for (int i = 0; i < 20 && REQ_READY_OUT !== 1'b1; i++) @(negedge CLK_IN);
      REQ_VALID_IN = 1'b1;
      REQ_OP_IN = op;
      REQ_PARTIAL_IN = part;
      REQ_TAG_IN = tg;
      do begin
         @(negedge CLK_IN);
         if (n == 0) REQ_VALID_IN = 1'b0;
         st += int'(!L2_BURST_STEP_N_OUT);
         rd += int'(!L2_READ_DRIVE_N_OUT);
         al += int'(!L2_ALL_LANES_WRITE_N_OUT);
         ln += int'(!L2_LANE_WRITE_N_OUT);
         n++;
      end while (DONE_OUT !== 1'b1 && n < 20);
      check(n, lat[op]);
      check(REQ_READY_OUT, 1'b1);
      check(st, op == 3 ? 0 : 3);
      check(rd, op == 0 ? 4 : 0);
      if (op == 1 || op == 2) check(al, (op == 1 && part) ? 0 : 4);
      if (op == 1 || op == 2) check(ln, (op == 1 && part) ? 4 : 0);
      if (op >= 2) tag_q = tg;
      if (op == 0) check(TAG_READ_OUT, tag_q);
   endtask : run_op
   task automatic do_reset(input logic k);
      NRST_IN = 1'b0;
      krq = k;
      repeat (8) @(negedge CLK_IN);
      NRST_IN = 1'b1;
      repeat (5) @(negedge CLK_IN);
      krq = 1'b0;
      check(DRAM_CACHE_PRESENT_OUT, k);
   endtask : do_reset
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test
   // ==========================================================
   // clock, watchdog, sequence
   initial begin
      CLK_IN = 1'b0;
      forever #2 CLK_IN = ~CLK_IN;
   end
   initial begin
      #100000;
      mismatches++;
      stop_test();
   end
   initial begin
      {REQ_VALID_IN, REQ_PARTIAL_IN, SLEEP_REQ_IN, REFRESH_REQ_IN, FIFTH_ROW_SELECT_REQ_IN} = '0;
      {REQ_OP_IN, REQ_TAG_IN, SDRAM_CONTROL_REG_IN, CACHE_CONFIG_REG_IN, tag_q} = '0;
      void'($urandom(80186));
      do_reset(1'b1);
      do_reset(1'b0);
      $display("strap test done");
      for (int i = 0; i < 24; i++) run_op(2'($urandom_range(3)), 1'($urandom), 8'($urandom));
      $display("transfer test done");
      SLEEP_REQ_IN = 1'b1;
      repeat (4) @(negedge CLK_IN);
      check(asleep, 1'b1);
      SLEEP_REQ_IN = 1'b0;
      run_op(2'h0, 1'b0, 8'h00);
      check(asleep, 1'b0);
      $display("sleep test done");
      for (int c = 0; c < 4; c++) begin
         SDRAM_CONTROL_REG_IN = {6'h00, c[0], 1'b0};
         CACHE_CONFIG_REG_IN = {2'h0, c[1], 5'h00};
         FIFTH_ROW_SELECT_REQ_IN = 1'($urandom);
         REFRESH_REQ_IN = 1'b1;
         repeat (4) @(negedge CLK_IN);
         check(DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT, 1'b1);
         check(DRAM_CACHE_REFRESH_HANDSHAKE_OUT, c == 1 ? !FIFTH_ROW_SELECT_REQ_IN : 1'b1);
         check(FIFTH_ROW_SELECT_N_OUT, c == 1 ? !FIFTH_ROW_SELECT_REQ_IN : 1'b1);
         REFRESH_REQ_IN = 1'b0;
         krq = c != 1;
         repeat (4) @(negedge CLK_IN);
         check(DRAM_CACHE_REFRESH_HANDSHAKE_OE_OUT, c == 1);
         check(REFRESH_ACK_OUT, c != 1);
         check(REFRESH_REQ_SEEN_OUT, c != 1);
         krq = 1'b0;
      end
      $display("shared pin test done");
      stop_test();
   end
endmodule : l2ctl_tb_top
`default_nettype wire
